// >>> design/adc_input_select_pkg.sv
// package: register map, field layout and encodings of the converter input select block
// Behaviour
// - 10-bit mode, aux negative B: 11 -> inputs 9/10/11, 10 -> 6/7/8, else low reference.
// - 10-bit mode, aux positive B set -> inputs 3/4/5, clear -> inputs 0/1/2.
// - aux negative A at bits 2:1, same routing as the B field.
// - aux positive A at bit 0: set -> inputs 3/4/5, clear -> inputs 0/1/2.
// - primary negative B at bit 15: set -> input 1, clear -> low reference.
// - primary positive B at bits 12:8 selects analog input n for code n, 0..12.
// - primary negative A at bit 7: set -> input 1, clear -> low reference.
// - primary positive A at bits 4:0, same encoding as the B field.
// - unimplemented bits ignore writes and read as zero.
// - scan mask holds 13 bits at 12:0; set includes the input in the scan.
// - all scan bits writable; scanning an absent input converts the low reference.
// - pin config set: digital, port read enabled, mux input tied to analog ground.
// - pin config clear: analog, port read disabled, converter samples the pin.
// - pin config bits of absent inputs stay read/write but are ignored.
// - module disabled: pin config ignored, all shared pins forced digital.
// - bit x of scan mask and pin config maps to analog input x.
// - all implemented bits reset to zero.
// - resolution bit set: 12-bit single channel; clear: 10-bit four channels.
// - alternate sampling uses A then B selections; otherwise always A.
// - scanning steps primary positive through the mask during sample A.
package adc_input_select_pkg;
    localparam logic [11:0] AUX_SEL_ADDR     = 12'h000;
    localparam logic [11:0] PRI_SEL_ADDR     = 12'h004;
    localparam logic [11:0] SCAN_MASK_ADDR   = 12'h008;
    localparam logic [11:0] PIN_CFG_ADDR     = 12'h00c;
    localparam logic [11:0] MODE_CTRL_ADDR   = 12'h010;
    localparam logic [11:0] ROUTE_STAT_ADDR  = 12'h014;

    localparam logic [15:0] AUX_SEL_MASK   = 16'h0707;
    localparam logic [15:0] PRI_SEL_MASK   = 16'h9f9f;
    localparam logic [15:0] INPUT_MASK     = 16'h1fff;
    localparam logic [15:0] MODE_CTRL_MASK = 16'h000f;
    localparam logic [15:0] RESET_VALUE    = 16'h0000;

    localparam int AUX_POS_A = 0;
    localparam int AUX_NEG_A = 1;
    localparam int AUX_POS_B = 8;
    localparam int AUX_NEG_B = 9;
    localparam int PRI_POS_A = 0;
    localparam int PRI_NEG_A = 7;
    localparam int PRI_POS_B = 8;
    localparam int PRI_NEG_B = 15;

    localparam int MODE_TWELVE_BIT = 0;
    localparam int MODE_ALT        = 1;
    localparam int MODE_SCAN       = 2;
    localparam int MODE_DISABLE    = 3;

    localparam logic [1:0] AUX_NEG_HIGH = 2'h3;
    localparam logic [1:0] AUX_NEG_MID  = 2'h2;

    // mux codes: 0..12 are analog inputs, 13 is the low reference, 15 selects none
    localparam logic [3:0] SEL_LOW_REF = 4'hd;
    localparam logic [3:0] SEL_NONE    = 4'hf;
    localparam logic [3:0] SEL_IN1     = 4'h1;
    localparam logic [3:0] AUX_POS_LO  = 4'h0;
    localparam logic [3:0] AUX_POS_HI  = 4'h3;
    localparam logic [3:0] AUX_NEG_LO6 = 4'h6;
    localparam logic [3:0] AUX_NEG_HI9 = 4'h9;

    localparam logic [31:0] STAT_SEL_B   = 32'h0000_0100;
endpackage

// >>> design/adc_input_select.sv
// converter input channel select registers with APB slave and mux steering
module adc_input_select
    import adc_input_select_pkg::*;
#(
    parameter int          NUM_INPUTS   = 13,
    parameter logic [12:0] PRESENT_MASK = 13'h1fff
) (
    input  wire logic        pclk,                 // system clock, 25 MHz
    input  wire logic        presetn,              // async reset, active low
    input  wire logic        psel,                 // apb select
    input  wire logic        penable,              // apb access phase
    input  wire logic        pwrite,               // apb direction
    input  wire logic [11:0] paddr,                // apb byte address
    input  wire logic [31:0] pwdata,               // apb write data
    input  wire logic [3:0]  pstrb,                // apb byte strobes
    output logic      [31:0] prdata,               // apb read data
    output logic             pready,               // apb ready
    output logic             pslverr,              // apb error
    input  wire logic        sample_done,          // one-cycle pulse per finished sample
    output logic [3:0]       pri_pos_sel,          // primary positive mux code
    output logic [3:0]       pri_neg_sel,          // primary negative mux code
    output logic [3:0]       aux_pos_base,         // first input of aux positive trio
    output logic [3:0]       aux_neg_base,         // first input of aux negative trio
    output logic             aux_route_en,         // aux channels routed
    output logic [12:0]      pin_digital,          // pin digital, port read enabled
    output logic [12:0]      mux_to_ground         // mux input tied to analog ground
);
    logic [15:0] aux_reg, pri_reg, scan_reg, pin_digital_config_reg, mode_reg;
    logic        phase_b_reg;
    logic [3:0]  scan_idx_reg, scan_idx_next;
    logic [31:0] prdata_next;

    wire         wr_en   = psel && penable && pwrite;
    wire         rd_en   = psel && penable && !pwrite;
    wire         hit_aux = paddr == AUX_SEL_ADDR;
    wire         hit_pri = paddr == PRI_SEL_ADDR;
    wire         hit_scn = paddr == SCAN_MASK_ADDR;
    wire         hit_pcf = paddr == PIN_CFG_ADDR;
    wire         hit_mod = paddr == MODE_CTRL_ADDR;
    wire         hit_sta = paddr == ROUTE_STAT_ADDR;
    wire         mapped  = hit_aux | hit_pri | hit_scn | hit_pcf | hit_mod | hit_sta;
    wire [15:0]  lane    = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    wire twelve  = mode_reg[MODE_TWELVE_BIT];
    wire alt_en  = mode_reg[MODE_ALT];
    wire scan_en = mode_reg[MODE_SCAN];
    wire mod_off = mode_reg[MODE_DISABLE];

    // a write merges only strobed lanes; mask keeps unimplemented bits zero
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] msk);
        merge = ((old & ~lane) | (pwdata[15:0] & lane)) & msk;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_reg  <= RESET_VALUE;
            pri_reg  <= RESET_VALUE;
            scan_reg <= RESET_VALUE;
            pin_digital_config_reg <= RESET_VALUE;
            mode_reg <= RESET_VALUE;
        end else if (wr_en) begin
            if (hit_aux) aux_reg  <= merge(aux_reg, AUX_SEL_MASK);
            if (hit_pri) pri_reg  <= merge(pri_reg, PRI_SEL_MASK);
            if (hit_scn) scan_reg <= merge(scan_reg, INPUT_MASK);
            if (hit_pcf) pin_digital_config_reg <= merge(pin_digital_config_reg, INPUT_MASK);
            if (hit_mod) mode_reg <= merge(mode_reg, MODE_CTRL_MASK);
        end
    end

    // sample phase: alternates A/B per finished sample when alternate sampling on
    wire phase_b_next = !alt_en ? 1'b0 : (sample_done ? !phase_b_reg : phase_b_reg);

    // next scan entry: lowest set mask bit above the current one, wrapping
    always_comb begin
        scan_idx_next = scan_idx_reg;
        if (sample_done && scan_en && !phase_b_reg) begin
            scan_idx_next = scan_idx_reg;
            for (int k = NUM_INPUTS - 1; k >= 0; k--) begin
                if (scan_reg[k] && 4'(k) <= scan_idx_reg) scan_idx_next = 4'(k);
            end
            for (int k = NUM_INPUTS - 1; k >= 0; k--) begin
                if (scan_reg[k] && 4'(k) > scan_idx_reg) scan_idx_next = 4'(k);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_b_reg  <= 1'b0;
            scan_idx_reg <= 4'h0;
        end else begin
            phase_b_reg  <= phase_b_next;
            scan_idx_reg <= scan_idx_next;
        end
    end

    // selection fields for the active sample
    wire [4:0] pos_field = phase_b_reg ? pri_reg[PRI_POS_B +: 5] : pri_reg[PRI_POS_A +: 5];
    wire       neg_field = phase_b_reg ? pri_reg[PRI_NEG_B] : pri_reg[PRI_NEG_A];
    wire [1:0] aneg      = phase_b_reg ? aux_reg[AUX_NEG_B +: 2] : aux_reg[AUX_NEG_A +: 2];
    wire       apos      = phase_b_reg ? aux_reg[AUX_POS_B] : aux_reg[AUX_POS_A];
    wire [3:0] pos_idx   = (scan_en && !phase_b_reg) ? scan_idx_reg : pos_field[3:0];
    wire       pos_ok    = (scan_en && !phase_b_reg) || pos_field < 5'(NUM_INPUTS);
    // absent inputs convert the low reference
    wire [3:0] pos_code  = (pos_ok && PRESENT_MASK[pos_idx]) ? pos_idx : SEL_LOW_REF;
    wire [3:0] neg_code  = neg_field ? SEL_IN1 : SEL_LOW_REF;
    wire [3:0] aneg_code = (aneg == AUX_NEG_HIGH) ? AUX_NEG_HI9 :
                           (aneg == AUX_NEG_MID)  ? AUX_NEG_LO6 : SEL_LOW_REF;
    wire [3:0] apos_code = apos ? AUX_POS_HI : AUX_POS_LO;

    // disabled module forces every shared pin digital; absent pins ignore config
    wire [12:0] dig_next = mod_off ? 13'h1fff : (pin_digital_config_reg[12:0] & PRESENT_MASK);

    always_comb begin
        prdata_next = 32'h0000_0000;
        if (hit_aux) prdata_next = {16'h0000, aux_reg};
        if (hit_pri) prdata_next = {16'h0000, pri_reg};
        if (hit_scn) prdata_next = {16'h0000, scan_reg};
        if (hit_pcf) prdata_next = {16'h0000, pin_digital_config_reg};
        if (hit_mod) prdata_next = {16'h0000, mode_reg};
        if (hit_sta) prdata_next = (phase_b_reg ? STAT_SEL_B : 32'h0000_0000) | {28'h0000000, pos_code};
    end

    // one wait state: the answer comes from flops in the access phase's second cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata        <= 32'h0000_0000;
            pready        <= 1'b0;
            pslverr       <= 1'b0;
            pri_pos_sel   <= SEL_LOW_REF;
            pri_neg_sel   <= SEL_LOW_REF;
            aux_pos_base  <= AUX_POS_LO;
            aux_neg_base  <= SEL_LOW_REF;
            aux_route_en  <= 1'b1;
            pin_digital   <= 13'h0000;
            mux_to_ground <= 13'h0000;
        end else begin
            pready        <= psel && penable && !pready;
            pslverr       <= psel && penable && !pready && !mapped;
            prdata        <= (rd_en && !pready) ? prdata_next : 32'h0000_0000;
            pri_pos_sel   <= pos_code;
            pri_neg_sel   <= neg_code;
            aux_pos_base  <= twelve ? SEL_NONE : apos_code;
            aux_neg_base  <= twelve ? SEL_NONE : aneg_code;
            aux_route_en  <= !twelve;
            pin_digital   <= dig_next;
            mux_to_ground <= dig_next;
        end
    end

    a_aux_off_twelve: assert property (@(posedge pclk) disable iff (!presetn)
        twelve |=> !aux_route_en && aux_neg_base == SEL_NONE)
        else $error("aux routed in 12-bit mode");
    a_disable_forces_dig: assert property (@(posedge pclk) disable iff (!presetn)
        mod_off |=> pin_digital == 13'h1fff)
        else $error("pins not digital while disabled");
    a_neg_b_input1: assert property (@(posedge pclk) disable iff (!presetn)
        phase_b_reg && pri_reg[PRI_NEG_B] |=> pri_neg_sel == SEL_IN1)
        else $error("primary negative B wrong");
    a_neg_a_ref: assert property (@(posedge pclk) disable iff (!presetn)
        !phase_b_reg && !pri_reg[PRI_NEG_A] |=> pri_neg_sel == SEL_LOW_REF)
        else $error("primary negative A wrong");
    a_aux_neg_high: assert property (@(posedge pclk) disable iff (!presetn)
        !twelve && aneg == AUX_NEG_HIGH |=> aux_neg_base == AUX_NEG_HI9)
        else $error("aux negative code 11 wrong");
    a_aux_pos_hi: assert property (@(posedge pclk) disable iff (!presetn)
        !twelve && apos |=> aux_pos_base == AUX_POS_HI)
        else $error("aux positive wrong");
    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (scan_reg & ~INPUT_MASK) == 16'h0000 && (pri_reg & ~PRI_SEL_MASK) == 16'h0000)
        else $error("unimplemented bit set");
    a_no_alt_stays_a: assert property (@(posedge pclk) disable iff (!presetn)
        !alt_en |=> !phase_b_reg)
        else $error("sample B used without alternate");
    a_ground_tracks_dig: assert property (@(posedge pclk) disable iff (!presetn)
        !mod_off && pin_digital_config_reg[0] && PRESENT_MASK[0] |=> mux_to_ground[0] && pin_digital[0])
        else $error("pin config set not honoured");
    a_pos_b_field: assert property (@(posedge pclk) disable iff (!presetn)
        phase_b_reg && pri_reg[PRI_POS_B +: 5] < 5'(NUM_INPUTS) && PRESENT_MASK[pri_reg[PRI_POS_B +: 4]]
        |=> pri_pos_sel == $past(pri_reg[PRI_POS_B +: 4]))
        else $error("primary positive B wrong");
    a_absent_low_ref: assert property (@(posedge pclk) disable iff (!presetn)
        pos_ok && !PRESENT_MASK[pos_idx] |=> pri_pos_sel == SEL_LOW_REF)
        else $error("absent input not replaced by low reference");
    a_scan_pos_step: assert property (@(posedge pclk) disable iff (!presetn)
        scan_en && !phase_b_reg && PRESENT_MASK[scan_idx_reg] |=> pri_pos_sel == $past(scan_idx_reg))
        else $error("scan entry not routed");
    a_clear_is_analog: assert property (@(posedge pclk) disable iff (!presetn)
        !mod_off && !pin_digital_config_reg[1] |=> !pin_digital[1] && !mux_to_ground[1])
        else $error("pin config clear not analog");
    a_absent_pin_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        !mod_off |=> (pin_digital & ~PRESENT_MASK) == 13'h0000)
        else $error("absent pin config honoured");
endmodule

// >>> tb/sample_source.sv
// far-side stand-in: converter sequencer reporting finished samples
module sample_source (
    input  wire logic pclk,        // system clock
    input  wire logic presetn,     // async reset, active low
    input  wire logic start,       // request one sample
    output logic      sample_done  // one-cycle pulse per sample
);
    timeunit 1ns;
    timeprecision 1ns;
    // a held request still gives single pulses, never a level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sample_done <= 1'b0;
        else
            sample_done <= start & ~sample_done;
    end
endmodule

// >>> tb/adc_input_channel_select_tb.sv
// self-checking bench for the converter input select block
module adc_input_channel_select_tb
    import adc_input_select_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    // input 12 absent, so absent-input handling is reached
    localparam logic [12:0] PRES = 13'h0fff;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [3:0]  pstrb = 4'hf, pri_pos_sel, pri_neg_sel, aux_pos_base, aux_neg_base;
    logic        pready, pslverr, perr, sample_done, aux_route_en;
    logic [12:0] pin_digital, mux_to_ground;
    logic [15:0] lfsr = 16'h0052, v;
    logic [15:0] masks [4] = '{AUX_SEL_MASK, PRI_SEL_MASK, INPUT_MASK, INPUT_MASK};
    int          n_mismatch = 0, total_checks = 0, cyc = 0;

    adc_input_select #(.PRESENT_MASK(PRES)) adc_input_select_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_done(sample_done),
        .pri_pos_sel(pri_pos_sel), .pri_neg_sel(pri_neg_sel), .aux_pos_base(aux_pos_base),
        .aux_neg_base(aux_neg_base), .aux_route_en(aux_route_en), .pin_digital(pin_digital),
        .mux_to_ground(mux_to_ground));
    sample_source sample_source_inst (.pclk(pclk), .presetn(presetn), .start(start), .sample_done(sample_done));

    always #20 pclk = ~pclk;

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            final_report();
        end
    end

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    function automatic logic [3:0] pos_exp(input logic [4:0] c);
        return (c <= 5'd12 && PRES[c[3:0]]) ? c[3:0] : SEL_LOW_REF;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // entered just after an edge; the first edge only separates transfers
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rst();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic samp();
        @(posedge pclk);
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    // sh 0 checks the sample A fields, sh 8 the sample B fields
    task automatic chk_sel(input int sh);
        logic [15:0] f;
        f = v >> sh;
        check("pri_pos", pri_pos_sel, pos_exp(f[4:0]));
        check("pri_neg", pri_neg_sel, f[7] ? SEL_IN1 : SEL_LOW_REF);
        check("aux_pos", aux_pos_base, f[0] ? 4'h3 : 4'h0);
        check("aux_neg", aux_neg_base, f[2:1] == 2'h3 ? 4'h9 : f[2:1] == 2'h2 ? 4'h6 : SEL_LOW_REF);
        check("aux_en", aux_route_en, 1'b1);
    endtask

    initial begin
        rst();
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            check("reset", rd, 32'h0);
        end
        check("neg_rst", pri_neg_sel, SEL_LOW_REF);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'(4 * i), 32'hffff_ffff);
            apb(1'b0, 12'(4 * i), 32'h0);
            check("mask", rd, {16'h0000, masks[i]});
        end
        apb(1'b0, 12'h018, 32'h0);
        check("slverr", perr, 1'b1);
        check("unmapped", rd, 32'h0);
        apb(1'b1, MODE_CTRL_ADDR, 32'h2);
        for (int i = 0; i < 12; i++) begin
            v = (i == 0) ? 16'h0b8d : (i == 1) ? 16'h8c0b : rnd();
            apb(1'b1, AUX_SEL_ADDR, {16'h0000, v});
            apb(1'b1, PRI_SEL_ADDR, {16'h0000, v});
            repeat (2) @(posedge pclk);
            chk_sel(0);
            samp();
            chk_sel(8);
            apb(1'b0, ROUTE_STAT_ADDR, 32'h0);
            check("status", rd, STAT_SEL_B | {28'h0000000, pos_exp(v[12:8])});
            samp();
        end
        apb(1'b1, MODE_CTRL_ADDR, 32'h1);
        repeat (2) @(posedge pclk);
        check("aux_en", aux_route_en, 1'b0);
        check("aux_pos", aux_pos_base, SEL_NONE);
        check("aux_neg", aux_neg_base, SEL_NONE);
        rst();
        apb(1'b1, SCAN_MASK_ADDR, 32'h1024);
        apb(1'b1, MODE_CTRL_ADDR, 32'h4);
        for (int i = 0; i < 4; i++) begin
            samp();
            check("scan", pri_pos_sel, i == 0 ? 4'h2 : i == 1 ? 4'h5 : i == 2 ? SEL_LOW_REF : 4'h2);
        end
        v = rnd();
        apb(1'b1, PIN_CFG_ADDR, {16'h0000, v});
        repeat (2) @(posedge pclk);
        check("pin_dig", pin_digital, v[12:0] & PRES);
        check("mux_gnd", mux_to_ground, v[12:0] & PRES);
        apb(1'b1, MODE_CTRL_ADDR, 32'h8);
        repeat (2) @(posedge pclk);
        check("pin_off", pin_digital, 13'h1fff);
        final_report();
    end
endmodule
